// [src/i2cm_brg.sv]
// Baud-rate counter that pulses once per half bit period.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_params.svh"
module i2cm_brg (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [`I2CM_BRG_W-1:0] reload,
  output logic tick
);
  logic [`I2CM_BRG_W-1:0] cnt_reg;
  logic [`I2CM_BRG_W-1:0] cnt_next;

  assign tick = run && (cnt_reg == `I2CM_BRG_RST);

  // A halted counter is reloaded so every half period starts whole.
  always_comb begin
    if (!run || tick) begin
      cnt_next = reload;
    end else begin
      cnt_next = cnt_reg - `I2CM_BRG_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= `I2CM_BRG_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  a_brg_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    tick |=> cnt_reg == $past(reload))
    else $error("baud counter did not reload on rollover");
endmodule
`default_nettype wire

// [src/i2cm_params.svh]
// Constants for the two-wire master receive block.
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH
`define I2CM_BRG_W 8
`define I2CM_BRG_RST 8'h00
`define I2CM_CNT_W 4
`define I2CM_CNT_RST 4'h0
`define I2CM_CNT_STEP 4'h1
`define I2CM_LAST_BIT 4'h7
`define I2CM_ACK_SLOT 4'h8
`define I2CM_BYTE_RST 8'h00
`define I2CM_DRIVE_LOW 1'b0
`define I2CM_RELEASED 1'b1
`define I2CM_SYNC_RST 2'h3
`endif

// [src/i2cm_pkg.sv]
// Types shared by the two-wire master receive block.
package i2cm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_TX = 3'h3,
    ST_RX = 3'h2,
    ST_ACK = 3'h6,
    ST_STOP = 3'h7
  } i2cm_state_t;
endpackage

// [src/i2cm_rx.sv]
// Two-wire bus master with start, address, byte receive, acknowledge and stop.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_params.svh"
module i2cm_rx (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [`I2CM_BRG_W-1:0] brg_reload,
  input wire logic start_condition_enable,
  input wire logic stop_condition_enable,
  input wire logic receive_enable_set,
  input wire logic ack_sequence_enable,
  input wire logic ack_data_value,
  input wire logic buf_wr,
  input wire logic [7:0] buf_wdata,
  input wire logic buf_rd,
  input wire logic int_flag_clr,
  input wire logic overflow_clr,
  input wire logic collision_clr,
  input wire logic bus_collision_clr,
  output logic [7:0] port_data_buffer,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic write_collision_flag,
  output logic port_interrupt_flag,
  output logic ack_status_bit,
  output logic receive_enable_bit,
  output logic bus_collision_flag,
  output logic bus_idle
);
  import i2cm_pkg::*;

  i2cm_state_t state_reg, state_next;
  logic owned_reg, owned_next;
  logic scl_rel_reg, scl_rel_next;
  logic sda_rel_reg, sda_rel_next;
  logic [`I2CM_CNT_W-1:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] buf_reg, buf_next;
  logic bf_reg, bf_next;
  logic ovf_reg, ovf_next;
  logic write_collision_flag_reg, write_collision_flag_next;
  logic pif_reg, pif_next;
  logic ack_status_bit_reg, ack_status_bit_next;
  logic receive_enable_bit_reg, receive_enable_bit_next;
  logic bcol_reg, bcol_next;
  logic other_busy_reg, other_busy_next;
  logic sda_prev_reg, sda_prev_next;
  logic [1:0] lines_s;
  logic scl_s;
  logic sda_s;
  logic brg_run;
  logic brg_tick;
  logic high_tick;
  logic rx_done;
  logic collide;

  function automatic logic is_shifting(input i2cm_state_t st);
    is_shifting = (st != ST_IDLE);
  endfunction

  i2cm_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din({scl_in, sda_in}),
    .dout(lines_s)
  );

  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  // A released clock that still reads low is being stretched; the counter waits.
  assign brg_run = is_shifting(state_reg) && !(scl_rel_reg && !scl_s);

  i2cm_brg u_brg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(brg_run),
    .reload(brg_reload),
    .tick(brg_tick)
  );

  assign high_tick = brg_tick && scl_rel_reg;
  assign rx_done = (state_reg == ST_RX) && high_tick && (bit_cnt_reg == `I2CM_LAST_BIT);
  assign collide = (state_reg == ST_TX) && high_tick && sda_rel_reg && !sda_s &&
                   (bit_cnt_reg != `I2CM_ACK_SLOT);
  assign bus_idle = !owned_reg && !other_busy_reg && scl_s && sda_s;

  // Outputs are open-drain: the pin value is always low and only the enable moves.
  assign scl_out = `I2CM_DRIVE_LOW;
  assign sda_out = `I2CM_DRIVE_LOW;
  assign scl_oe = !scl_rel_reg;
  assign sda_oe = !sda_rel_reg;

  // A start seen while the bus is not owned (our own included) and any stop track whether the bus is taken.
  always_comb begin
    sda_prev_next = sda_s;
    other_busy_next = other_busy_reg;
    if (scl_s && sda_prev_reg && !sda_s && !owned_reg) begin
      other_busy_next = 1'b1;
    end else if (scl_s && !sda_prev_reg && sda_s) begin
      other_busy_next = 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    owned_next = owned_reg;
    scl_rel_next = scl_rel_reg;
    sda_rel_next = sda_rel_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    buf_next = buf_reg;
    ack_status_bit_next = ack_status_bit_reg;
    receive_enable_bit_next = receive_enable_bit_reg;
    bf_next = bf_reg && !buf_rd;
    ovf_next = ovf_reg && !overflow_clr;
    write_collision_flag_next = write_collision_flag_reg && !collision_clr;
    pif_next = pif_reg && !int_flag_clr;
    bcol_next = bcol_reg && !bus_collision_clr;
    if (buf_wr && is_shifting(state_reg)) begin
      write_collision_flag_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_condition_enable && bus_idle) begin
          state_next = ST_START;
          sda_rel_next = `I2CM_DRIVE_LOW;
        end else if (owned_reg && stop_condition_enable) begin
          state_next = ST_STOP;
          sda_rel_next = `I2CM_DRIVE_LOW;
        end else if (buf_wr) begin
          buf_next = buf_wdata;
          if (owned_reg) begin
            state_next = ST_TX;
            shift_next = buf_wdata;
            sda_rel_next = buf_wdata[7];
            bit_cnt_next = `I2CM_CNT_RST;
          end
        end else if (owned_reg && receive_enable_set) begin
          state_next = ST_RX;
          receive_enable_bit_next = 1'b1;
          sda_rel_next = `I2CM_RELEASED;
          bit_cnt_next = `I2CM_CNT_RST;
        end else if (owned_reg && ack_sequence_enable) begin
          state_next = ST_ACK;
          sda_rel_next = ack_data_value;
        end
      end
      ST_START: begin
        if (brg_tick) begin
          scl_rel_next = `I2CM_DRIVE_LOW;
          owned_next = 1'b1;
          pif_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_TX: begin
        if (collide) begin
          bcol_next = 1'b1;
          owned_next = 1'b0;
          scl_rel_next = `I2CM_RELEASED;
          sda_rel_next = `I2CM_RELEASED;
          state_next = ST_IDLE;
        end else if (high_tick) begin
          scl_rel_next = `I2CM_DRIVE_LOW;
          if (bit_cnt_reg == `I2CM_ACK_SLOT) begin
            ack_status_bit_next = sda_s;
            pif_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            bit_cnt_next = bit_cnt_reg + `I2CM_CNT_STEP;
            shift_next = {shift_reg[6:0], 1'b0};
            sda_rel_next = (bit_cnt_reg == `I2CM_LAST_BIT) ? `I2CM_RELEASED : shift_reg[6];
          end
        end else if (brg_tick) begin
          scl_rel_next = `I2CM_RELEASED;
        end
      end
      ST_RX: begin
        if (high_tick) begin
          scl_rel_next = `I2CM_DRIVE_LOW;
          shift_next = {shift_reg[6:0], sda_s};
          bit_cnt_next = bit_cnt_reg + `I2CM_CNT_STEP;
          if (rx_done) begin
            buf_next = {shift_reg[6:0], sda_s};
            bf_next = 1'b1;
            ovf_next = ovf_next || bf_reg;
            pif_next = 1'b1;
            receive_enable_bit_next = 1'b0;
            state_next = ST_IDLE;
          end
        end else if (brg_tick) begin
          scl_rel_next = `I2CM_RELEASED;
        end
      end
      ST_ACK: begin
        if (high_tick) begin
          scl_rel_next = `I2CM_DRIVE_LOW;
          sda_rel_next = `I2CM_RELEASED;
          pif_next = 1'b1;
          state_next = ST_IDLE;
        end else if (brg_tick) begin
          scl_rel_next = `I2CM_RELEASED;
        end
      end
      ST_STOP: begin
        if (high_tick) begin
          sda_rel_next = `I2CM_RELEASED;
          owned_next = 1'b0;
          pif_next = 1'b1;
          state_next = ST_IDLE;
        end else if (brg_tick) begin
          scl_rel_next = `I2CM_RELEASED;
        end
      end
      default: begin
        state_next = ST_IDLE;
        scl_rel_next = `I2CM_RELEASED;
        sda_rel_next = `I2CM_RELEASED;
        owned_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      owned_reg <= 1'b0;
      scl_rel_reg <= `I2CM_RELEASED;
      sda_rel_reg <= `I2CM_RELEASED;
      bit_cnt_reg <= `I2CM_CNT_RST;
      shift_reg <= `I2CM_BYTE_RST;
      buf_reg <= `I2CM_BYTE_RST;
      bf_reg <= 1'b0;
      ovf_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      pif_reg <= 1'b0;
      ack_status_bit_reg <= 1'b0;
      receive_enable_bit_reg <= 1'b0;
      bcol_reg <= 1'b0;
      other_busy_reg <= 1'b0;
      sda_prev_reg <= `I2CM_RELEASED;
    end else begin
      state_reg <= state_next;
      owned_reg <= owned_next;
      scl_rel_reg <= scl_rel_next;
      sda_rel_reg <= sda_rel_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      buf_reg <= buf_next;
      bf_reg <= bf_next;
      ovf_reg <= ovf_next;
      write_collision_flag_reg <= write_collision_flag_next;
      pif_reg <= pif_next;
      ack_status_bit_reg <= ack_status_bit_next;
      receive_enable_bit_reg <= receive_enable_bit_next;
      bcol_reg <= bcol_next;
      other_busy_reg <= other_busy_next;
      sda_prev_reg <= sda_prev_next;
    end
  end

  assign port_data_buffer = buf_reg;
  assign buffer_full_flag = bf_reg;
  assign receive_overflow_flag = ovf_reg;
  assign write_collision_flag = write_collision_flag_reg;
  assign port_interrupt_flag = pif_reg;
  assign ack_status_bit = ack_status_bit_reg;
  assign receive_enable_bit = receive_enable_bit_reg;
  assign bus_collision_flag = bcol_reg;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rx_last_edge;
    state_reg == ST_RX && high_tick && bit_cnt_reg == `I2CM_LAST_BIT;
  endsequence

  sequence s_addr_ack_edge;
    state_reg == ST_TX && high_tick && bit_cnt_reg == `I2CM_ACK_SLOT;
  endsequence

  a_receive_enable_bit_busy_ignored: assert property (
    receive_enable_set && state_reg != ST_IDLE |=> state_reg != ST_RX)
    else $error("receive enable taken while port busy");

  a_rx_clock_toggle: assert property (
    state_reg == ST_RX && brg_tick |=> scl_rel_reg != $past(scl_rel_reg))
    else $error("clock did not toggle on rollover");

  a_rx_byte_done: assert property (
    s_rx_last_edge |=> bf_reg && pif_reg && !receive_enable_bit_reg && !scl_rel_reg &&
      state_reg == ST_IDLE && buf_reg == $past({shift_reg[6:0], sda_s}))
    else $error("received byte not completed correctly");

  a_read_clears_full: assert property (
    buf_rd && !rx_done |=> !bf_reg)
    else $error("buffer read did not clear full flag");

  a_overflow_set: assert property (
    rx_done && bf_reg |=> ovf_reg)
    else $error("overflow not flagged");

  a_write_collision_flag_keeps_buf: assert property (
    buf_wr && state_reg != ST_IDLE && !rx_done |=> write_collision_flag_reg && $stable(buf_reg))
    else $error("write during shift not handled");

  a_start_flag: assert property (
    state_reg == ST_START && brg_tick |=> pif_reg && owned_reg && !scl_rel_reg)
    else $error("start completion not flagged");

  a_addr_begin: assert property (
    buf_wr && state_reg == ST_IDLE && owned_reg && !start_condition_enable &&
      !stop_condition_enable |=> state_reg == ST_TX && sda_rel_reg == $past(buf_wdata[7]))
    else $error("address shift did not begin");

  a_addr_ack_stat: assert property (
    s_addr_ack_edge |=> ack_status_bit_reg == $past(sda_s) && pif_reg && state_reg == ST_IDLE)
    else $error("address acknowledge not captured");

  a_ack_bit_out: assert property (
    state_reg == ST_ACK |-> sda_rel_reg == $past(ack_data_value, 1) || $past(state_reg) == ST_ACK)
    else $error("acknowledge bit not driven");

  a_start_needs_idle: assert property (
    state_reg == ST_IDLE && start_condition_enable && !bus_idle |=> state_reg != ST_START)
    else $error("start issued on a busy bus");

  a_collision_abort: assert property (
    collide |=> bcol_reg && state_reg == ST_IDLE && scl_rel_reg && sda_rel_reg)
    else $error("collision not handled");

  a_stretch_holds: assert property (
    scl_rel_reg && !scl_s && is_shifting(state_reg) |=> $stable(bit_cnt_reg) && $stable(shift_reg))
    else $error("master advanced during clock stretch");
endmodule
`default_nettype wire

// [src/i2cm_sync.sv]
// Two-flop synchroniser for the bus lines.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_params.svh"
module i2cm_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;

  // Lines idle high through the pull-ups, so reset to released.
  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= `I2CM_SYNC_RST;
      sync_reg <= `I2CM_SYNC_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule
`default_nettype wire

// [tb/i2cm_slave_model.sv]
// Behavioural two-wire slave that acknowledges an address and returns read bytes.
`timescale 1ns/1ps
`default_nettype none
module i2cm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rd_byte,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe,
  output logic [7:0] addr_seen,
  output logic mack_seen
);
  int cnt;
  logic active;
  logic rd_mode;
  logic [7:0] tx;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    active = 1'b0;
    rd_mode = 1'b0;
    cnt = 0;
    tx = 8'hff;
    addr_seen = 8'h00;
    mack_seen = 1'b0;
  end
  // The master moves data in the same step as the clock falls, so look again a moment later.
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b0) begin
      active = 1'b1;
      rd_mode = 1'b0;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1 && sda === 1'b1) begin
      active = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (active) begin
      cnt = cnt + 1;
      if (cnt <= 8 && !rd_mode) begin
        addr_seen = {addr_seen[6:0], sda};
      end
      if (cnt == 9 && rd_mode) begin
        mack_seen = sda;
      end
    end
  end
  // Data changes only while the clock is low, so a start or stop is never faked.
  always @(negedge scl) begin
    if (active) begin
      if (cnt == 8) begin
        sda_oe = !rd_mode;
      end else begin
        if (cnt == 9) begin
          cnt = 0;
          if (!rd_mode) begin
            rd_mode = addr_seen[0];
            tx = rd_byte;
          end else if (mack_seen) begin
            active = 1'b0;
          end else begin
            tx = rd_byte;
          end
        end
        sda_oe = active && rd_mode && !tx[7];
        tx = {tx[6:0], 1'b1};
      end
    end
  end
  // Holding the clock well past the master's half period tests its wait.
  always @(negedge scl) begin
    if (active && stretch) begin
      scl_oe = 1'b1;
      #200;
      scl_oe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the two-wire master receive block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst_n, ackv, jam, stretch;
  logic [9:0] cmd;
  logic [7:0] wdata, rd_byte, port_data_buffer, addr_seen;
  logic scl, sda, scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe, mack_seen;
  logic buffer_full_flag, receive_overflow_flag, write_collision_flag, port_interrupt_flag;
  logic ack_status_bit, receive_enable_bit, bus_collision_flag, bus_idle;
  logic scl_oe_q, s_q;
  int n_errors, n_compared;
  // Both lines are open drain with pull-ups: any driver pulls low.
  assign scl = ~(scl_oe | s_scl_oe);
  assign sda = ~(sda_oe | s_sda_oe | jam);
  i2cm_rx dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .brg_reload(8'h05),
    .start_condition_enable(cmd[0]), .stop_condition_enable(cmd[1]),
    .receive_enable_set(cmd[2]), .ack_sequence_enable(cmd[3]), .ack_data_value(ackv),
    .buf_wr(cmd[4]), .buf_wdata(wdata), .buf_rd(cmd[5]), .int_flag_clr(cmd[6]),
    .overflow_clr(cmd[7]), .collision_clr(cmd[8]), .bus_collision_clr(cmd[9]),
    .port_data_buffer(port_data_buffer), .buffer_full_flag(buffer_full_flag),
    .receive_overflow_flag(receive_overflow_flag), .write_collision_flag(write_collision_flag),
    .port_interrupt_flag(port_interrupt_flag), .ack_status_bit(ack_status_bit),
    .receive_enable_bit(receive_enable_bit), .bus_collision_flag(bus_collision_flag),
    .bus_idle(bus_idle)
  );
  i2cm_slave_model u_slave (
    .scl(scl), .sda(sda), .rd_byte(rd_byte), .stretch(stretch), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe), .addr_seen(addr_seen), .mack_seen(mack_seen)
  );
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One command pulse of one cycle; data and acknowledge value ride along.
  task automatic fire(input logic [9:0] c, input logic [7:0] d);
    @(posedge core_clk);
    cmd <= c;
    wdata <= d;
    ackv <= d[0];
    @(posedge core_clk);
    cmd <= 10'h000;
  endtask
  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      #1;
      if ((sel == 0 && port_interrupt_flag === 1'b1) || (sel == 1 &&
          bus_collision_flag === 1'b1) || (sel == 2 && bus_idle === 1'b1)) begin
        break;
      end
    end
    if (i == 3000) begin
      n_errors++;
      $display("mismatch wait_%0d expected 1 seen timeout", sel);
      close_out();
    end
  endtask
  // The design may release the clock while the slave holds it, never pull it again.
  always @(negedge core_clk) begin
    if (rst_n === 1'b1 && (scl_out !== 1'b0 || sda_out !== 1'b0)) begin
      n_errors++;
      $display("mismatch line_drive expected 0 seen %b%b", scl_out, sda_out);
    end
    if (s_q && s_scl_oe && scl_oe_q === 1'b0 && scl_oe === 1'b1) begin
      n_errors++;
      $display("mismatch stretch_wait expected 0 seen 1");
    end
    scl_oe_q = scl_oe;
    s_q = s_scl_oe;
  end
  initial begin
    rst_n = 1'b0;
    cmd = 10'h000;
    wdata = 8'h00;
    ackv = 1'b0;
    jam = 1'b0;
    stretch = 1'b0;
    rd_byte = 8'hc3;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("reset_lines", 8'h00, {6'h00, scl_oe, sda_oe});
    check("reset_flags", 8'h00, {2'h0, buffer_full_flag, receive_overflow_flag,
      write_collision_flag, port_interrupt_flag, receive_enable_bit, bus_collision_flag});
    check("idle_free", 8'h01, {7'h00, bus_idle});
    fire(10'h004, 8'h00);
    #1;
    check("receive_enable_bit_unowned", 8'h00, {7'h00, receive_enable_bit});
    fire(10'h001, 8'h00);
    wait_hi(0);
    check("start_lines", 8'h03, {6'h00, scl_oe, sda_oe});
    check("idle_owned", 8'h00, {7'h00, bus_idle});
    fire(10'h040, 8'h00);
    fire(10'h010, 8'h6b);
    repeat (6) @(posedge core_clk);
    fire(10'h004, 8'h00);
    #1;
    check("receive_enable_bit_busy", 8'h00, {7'h00, receive_enable_bit});
    wait_hi(0);
    check("addr", 8'h6b, addr_seen);
    check("ack_status_bit", 8'h00, {7'h00, ack_status_bit});
    fire(10'h040, 8'h00);
    stretch <= 1'b1;
    fire(10'h004, 8'h00);
    #1;
    check("receive_enable_bit_set", 8'h01, {7'h00, receive_enable_bit});
    fire(10'h010, 8'h55);
    wait_hi(0);
    stretch <= 1'b0;
    check("rx_byte", 8'hc3, port_data_buffer);
    check("rx_done", 8'h0d, {4'h0, buffer_full_flag, write_collision_flag,
      receive_enable_bit, scl_oe});
    fire(10'h140, 8'h00);
    rd_byte <= 8'h3c;
    fire(10'h008, 8'h00);
    wait_hi(0);
    check("mack_ack", 8'h00, {7'h00, mack_seen});
    fire(10'h040, 8'h00);
    fire(10'h004, 8'h00);
    wait_hi(0);
    check("ovf_byte", 8'h3c, port_data_buffer);
    check("ovf_flags", 8'h06, {5'h00, buffer_full_flag, receive_overflow_flag,
      write_collision_flag});
    fire(10'h060, 8'h00);
    #1;
    check("bf_read", 8'h00, {7'h00, buffer_full_flag});
    fire(10'h008, 8'h01);
    wait_hi(0);
    check("mack_nack", 8'h01, {7'h00, mack_seen});
    fire(10'h0c0, 8'h00);
    fire(10'h002, 8'h00);
    wait_hi(2);
    check("ovf_clr", 8'h00, {7'h00, receive_overflow_flag});
    // The stop left the interrupt flag set, so it is cleared together with the new start.
    fire(10'h041, 8'h00);
    wait_hi(0);
    fire(10'h040, 8'h00);
    fire(10'h010, 8'hff);
    jam <= 1'b1;
    wait_hi(1);
    repeat (2) @(posedge core_clk);
    #1;
    check("bcol_release", 8'h00, {7'h00, sda_oe});
    fire(10'h240, 8'h00);
    fire(10'h001, 8'h00);
    repeat (40) @(posedge core_clk);
    #1;
    check("start_busy", 8'h00, {6'h00, port_interrupt_flag, bus_collision_flag});
    jam <= 1'b0;
    close_out();
  end
endmodule
`default_nettype wire
